/* File: icsr_regs.svh */
`ifndef ICSR_REGS_SVH
`define ICSR_REGS_SVH
`define ICSR_OFF_STATUS    12'h000
`define ICSR_OFF_CORCTL    12'h004
`define ICSR_OFF_CTL1      12'h008
`define ICSR_OFF_CTL2      12'h00C
`define ICSR_OFF_FLAG      12'h010
`define ICSR_OFF_ENABLE    12'h014
`define ICSR_OFF_PRIO      12'h018
`define ICSR_OFF_PEND      12'h01C
`define ICSR_OFF_IRQ_STAT  12'h020
`define ICSR_OFF_IRQ_MASK  12'h024
`define ICSR_STATUS_LVL_LSB 5
`define ICSR_CORCTL_HIGH    3
`define ICSR_CTL1_NEST      15
`define ICSR_CTL1_TRAP_MASK 16'h001E
`define ICSR_CTL2_ALT       15
`define ICSR_CTL2_DIS       14
`define ICSR_CTL2_EDGE_MASK 16'h0007
`define ICSR_LVL_USER_MAX   4'h7
`define ICSR_RESET_VAL      16'h0000
`endif

/* File: icsr_pkg.sv */
package icsr_pkg;
    typedef logic [3:0] icsr_level_t;
    typedef logic [6:0] icsr_vector_t;
    typedef enum logic [1:0] {ICSR_IDLE, ICSR_ACCESS} icsr_apb_state_t;
endpackage

/* File: icsr_edge_det.sv */
`timescale 1ns/1ps
`default_nettype none
module icsr_edge_det
    import icsr_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    input  wire logic pin_i,
    input  wire logic falling_i,
    output logic      pulse_o
);
    logic sync1;
    logic sync2;
    logic last;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            last  <= 1'b0;
        end else begin
            sync1 <= pin_i;
            sync2 <= sync1;
            last  <= sync2;
        end
    end
    // polarity select: 1 falling, 0 rising
    assign pulse_o = falling_i ? (last & ~sync2) : (~last & sync2);
endmodule // icsr_edge_det
`default_nettype wire

/* File: icsr_arbiter.sv */
`timescale 1ns/1ps
`default_nettype none
module icsr_arbiter
    import icsr_pkg::*;
#(
    parameter int NSRC = 8
) (
    input  wire logic [NSRC-1:0]   req_i,
    input  wire logic [3*NSRC-1:0] prio_i,
    input  wire icsr_level_t       cpu_level_i,
    output logic                   valid_o,
    output icsr_vector_t           vector_o,
    output icsr_level_t            level_o
);
    // descending scan, so the lowest index wins among equal priorities
    always_comb begin
        valid_o  = 1'b0;
        vector_o = 7'h00;
        level_o  = 4'h0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (req_i[i] && {1'b0, prio_i[3*i +: 3]} > cpu_level_i &&
                (!valid_o || prio_i[3*i +: 3] >= level_o[2:0])) begin
                valid_o  = 1'b1;
                vector_o = 7'(i);
                level_o  = {1'b0, prio_i[3*i +: 3]};
            end
        end
    end
endmodule // icsr_arbiter
`default_nettype wire

/* File: icsr_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "icsr_regs.svh"
module icsr_top
    import icsr_pkg::*;
#(
    parameter int NSRC = 8
) (
    input  wire logic              CLK_SYS_I,
    input  wire logic              RST_B_I,
    input  wire logic              PSEL_I,
    input  wire logic              PENABLE_I,
    input  wire logic              PWRITE_I,
    input  wire logic [11:0]       PADDR_I,
    input  wire logic [31:0]       PWDATA_I,
    output logic      [31:0]       PRDATA_O,
    output logic                   PREADY_O,
    output logic                   PSLVERR_O,
    input  wire logic [NSRC-1:0]   SRC_EVENT_I,
    input  wire logic [2:0]        EXT_PIN_I,
    input  wire logic [3:0]        TRAP_EVENT_I,
    input  wire logic              DISABLE_INSTR_I,
    input  wire logic              ACK_I,
    output logic                   CPU_REQ_O,
    output logic [6:0]             CPU_VECTOR_O,
    output logic [3:0]             CPU_LEVEL_O,
    output logic                   ALT_TABLE_O,
    output logic                   IRQ_O
);
    logic [2:0]       cpu_priority_low;
    logic             cpu_priority_high;
    logic             nesting_disable;
    logic [3:0]       trap_flags;
    logic             alternate_table_select;
    logic             intr_disable_instr_active;
    logic [2:0]       ext_edge_polarity;
    logic [NSRC-1:0]  request_flag_bank;
    logic [NSRC-1:0]  request_enable_bank;
    logic [3*NSRC-1:0] source_priority_bank;
    icsr_vector_t     pending_vector_number;
    icsr_level_t      pending_level;
    logic [1:0]       irq_status;
    logic [1:0]       irq_mask;
    logic             dis_sync1;
    logic             dis_sync2;
    logic [2:0]       ext_pulse;
    logic             arb_valid;
    icsr_vector_t     arb_vector;
    icsr_level_t      arb_level;

    // apb decode; zero wait state so pready is a registered constant high
    wire         wr_en  = PSEL_I & PENABLE_I & PWRITE_I;
    wire         rd_en  = PSEL_I & ~PENABLE_I & ~PWRITE_I;
    wire [15:0]  wdata  = PWDATA_I[15:0];
    wire         hit_st = PADDR_I == `ICSR_OFF_STATUS;
    wire         hit_cc = PADDR_I == `ICSR_OFF_CORCTL;
    wire         hit_c1 = PADDR_I == `ICSR_OFF_CTL1;
    wire         hit_c2 = PADDR_I == `ICSR_OFF_CTL2;
    wire         hit_fl = PADDR_I == `ICSR_OFF_FLAG;
    wire         hit_en = PADDR_I == `ICSR_OFF_ENABLE;
    wire         hit_pr = PADDR_I == `ICSR_OFF_PRIO;
    wire         hit_pe = PADDR_I == `ICSR_OFF_PEND;
    wire         hit_is = PADDR_I == `ICSR_OFF_IRQ_STAT;
    wire         hit_im = PADDR_I == `ICSR_OFF_IRQ_MASK;
    wire         hit_any = hit_st | hit_cc | hit_c1 | hit_c2 | hit_fl | hit_en |
                           hit_pr | hit_pe | hit_is | hit_im;

    // external pins feed sources 0..2 through selectable edge detect
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_ext
            icsr_edge_det u_edge (
                .clk_i     (CLK_SYS_I),
                .rst_b_i   (RST_B_I),
                .pin_i     (EXT_PIN_I[g]),
                .falling_i (ext_edge_polarity[g]),
                .pulse_o   (ext_pulse[g])
            );
        end
    endgenerate

    wire [NSRC-1:0] set_src = SRC_EVENT_I | {{(NSRC-3){1'b0}}, ext_pulse};
    // set wins over a software clear in the same cycle
    wire [NSRC-1:0] next_flag = (wr_en && hit_fl) ?
        ((request_flag_bank & wdata[NSRC-1:0]) | set_src) :
        (request_flag_bank | set_src);
    wire [NSRC-1:0] fwd_req = request_flag_bank & request_enable_bank;

    wire [3:0] cpu_level = {cpu_priority_high, cpu_priority_low};
    wire [3:0] next_trap = (wr_en && hit_c1) ?
        ((trap_flags & wdata[4:1]) | TRAP_EVENT_I) : (trap_flags | TRAP_EVENT_I);

    icsr_arbiter #(.NSRC(NSRC)) u_arb (
        .req_i       (fwd_req),
        .prio_i      (source_priority_bank),
        .cpu_level_i (cpu_level),
        .valid_o     (arb_valid),
        .vector_o    (arb_vector),
        .level_o     (arb_level)
    );

    // interrupt events: bit0 any trap, bit1 new pending request
    wire [1:0] irq_evt = {arb_valid & ~CPU_REQ_O, |TRAP_EVENT_I};
    wire [1:0] next_irq_status = ((wr_en && hit_is) ? (irq_status & ~wdata[1:0]) : irq_status)
                                 | irq_evt;

    always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            dis_sync1 <= 1'b0;
            dis_sync2 <= 1'b0;
        end else begin
            dis_sync1 <= DISABLE_INSTR_I;
            dis_sync2 <= dis_sync1;
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            cpu_priority_low          <= 3'h0;
            cpu_priority_high         <= 1'b0;
            nesting_disable           <= 1'b0;
            trap_flags                <= 4'h0;
            alternate_table_select    <= 1'b0;
            intr_disable_instr_active <= 1'b0;
            ext_edge_polarity         <= 3'h0;
            request_flag_bank         <= '0;
            request_enable_bank       <= '0;
            source_priority_bank      <= '0;
            pending_vector_number     <= 7'h00;
            pending_level             <= 4'h0;
            irq_status                <= 2'h0;
            irq_mask                  <= 2'h0;
        end else begin
            request_flag_bank         <= next_flag;
            trap_flags                <= next_trap;
            irq_status                <= next_irq_status;
            intr_disable_instr_active <= dis_sync2;
            if (wr_en && hit_st && !nesting_disable) begin
                cpu_priority_low <= wdata[`ICSR_STATUS_LVL_LSB +: 3];
            end
            if (|TRAP_EVENT_I) begin
                cpu_priority_high <= 1'b1;
            end else if (wr_en && hit_cc && !wdata[`ICSR_CORCTL_HIGH]) begin
                cpu_priority_high <= 1'b0;
            end
            if (wr_en && hit_c1) begin
                nesting_disable <= wdata[`ICSR_CTL1_NEST];
            end
            if (wr_en && hit_c2) begin
                alternate_table_select <= wdata[`ICSR_CTL2_ALT];
                ext_edge_polarity      <= wdata[2:0];
            end
            if (wr_en && hit_en) begin
                request_enable_bank <= wdata[NSRC-1:0];
            end
            if (wr_en && hit_pr) begin
                source_priority_bank <= PWDATA_I[3*NSRC-1:0];
            end
            if (arb_valid) begin
                pending_vector_number <= arb_vector;
                pending_level         <= arb_level;
            end
            if (wr_en && hit_im) begin
                irq_mask <= wdata[1:0];
            end
        end
    end

    // read mux; unimplemented bits are zero by construction
    wire [15:0] rd_st = {8'h00, cpu_priority_low, 5'h00};
    wire [15:0] rd_cc = {12'h000, cpu_priority_high, 3'h0};
    wire [15:0] rd_c1 = {nesting_disable, 10'h000, trap_flags, 1'b0};
    wire [15:0] rd_c2 = {alternate_table_select, intr_disable_instr_active, 11'h000,
                         ext_edge_polarity};
    wire [15:0] rd_pe = {1'b0, pending_vector_number, 4'h0, pending_level};
    wire [31:0] rd_mux =
        hit_st ? {16'h0000, rd_st} :
        hit_cc ? {16'h0000, rd_cc} :
        hit_c1 ? {16'h0000, rd_c1} :
        hit_c2 ? {16'h0000, rd_c2} :
        hit_fl ? 32'(request_flag_bank) :
        hit_en ? 32'(request_enable_bank) :
        hit_pr ? 32'(source_priority_bank) :
        hit_pe ? {16'h0000, rd_pe} :
        hit_is ? {30'h0, irq_status} :
        hit_im ? {30'h0, irq_mask} : 32'h0000_0000;

    always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            PRDATA_O     <= 32'h0000_0000;
            PREADY_O     <= 1'b0;
            PSLVERR_O    <= 1'b0;
            CPU_REQ_O    <= 1'b0;
            CPU_VECTOR_O <= 7'h00;
            CPU_LEVEL_O  <= 4'h0;
            ALT_TABLE_O  <= 1'b0;
            IRQ_O        <= 1'b0;
        end else begin
            PREADY_O     <= 1'b1;
            PSLVERR_O    <= PSEL_I & ~PENABLE_I & ~hit_any;
            if (rd_en) begin
                PRDATA_O <= rd_mux;
            end
            CPU_REQ_O    <= arb_valid & ~ACK_I;
            CPU_VECTOR_O <= arb_vector;
            CPU_LEVEL_O  <= arb_level;
            ALT_TABLE_O  <= alternate_table_select;
            IRQ_O        <= |(next_irq_status & irq_mask);
        end
    end

    AST_FLAG_STICKY: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
        (request_flag_bank[0] && !(wr_en && hit_fl)) |=> request_flag_bank[0])
        else $error("flag dropped without a write");
    AST_ENABLE_GATE: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
        (request_enable_bank == '0) |=> !CPU_REQ_O)
        else $error("disabled source forwarded");
    AST_PRIO_WRITE: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
        (wr_en && hit_pr) |=> source_priority_bank == $past(PWDATA_I[3*NSRC-1:0]))
        else $error("priority write lost");
    AST_LATCH: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
        arb_valid |=> pending_vector_number == $past(arb_vector))
        else $error("vector not latched");
    AST_NEST_LOCK: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
        (nesting_disable && wr_en && hit_st) |=> $stable(cpu_priority_low))
        else $error("level written while nesting disabled");
    AST_HIGH_NOSET: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
        (!cpu_priority_high && TRAP_EVENT_I == 4'h0) |=> !cpu_priority_high)
        else $error("high level bit set by software");
    AST_LEVEL_BLOCK: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
        (cpu_level >= `ICSR_LVL_USER_MAX) |-> !arb_valid)
        else $error("request above user ceiling");
    AST_DIS_FOLLOW: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
        DISABLE_INSTR_I [*4] |-> intr_disable_instr_active)
        else $error("disable status not following");
    AST_TIE: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
        (arb_valid && fwd_req[0] && source_priority_bank[2:0] == arb_level[2:0])
        |-> arb_vector == 7'h00)
        else $error("tie not won by lowest vector");

    // flag, enable and priority banks: flag hardware set and software clear checked apart so a set-wins slip shows
    AST_FLAG_SET: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
        (SRC_EVENT_I != '0) |=> (request_flag_bank & $past(SRC_EVENT_I)) == $past(SRC_EVENT_I))
        else $error("source event did not set its flag");
    AST_FLAG_CLEAR: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
        (wr_en && hit_fl && set_src == '0)
        |=> request_flag_bank == $past(request_flag_bank & wdata[NSRC-1:0]))
        else $error("flag write not applied");
    AST_ENABLE_WRITE: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
        (wr_en && hit_en) |=> request_enable_bank == $past(wdata[NSRC-1:0]))
        else $error("enable write lost");
    AST_FWD_MASK: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
        !request_enable_bank[0] |-> !(arb_valid && arb_vector == 7'h00))
        else $error("disabled source won arbitration");
    AST_PRIO_HOLD: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
        !(wr_en && hit_pr) |=> $stable(source_priority_bank))
        else $error("priority changed without a write");

    // pending latch and request outputs
    AST_PEND_LEVEL: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
        arb_valid |=> pending_level == $past(arb_level))
        else $error("level not latched");
    AST_PEND_HOLD: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
        !arb_valid |=> $stable(pending_vector_number) && $stable(pending_level))
        else $error("latch moved with nothing pending");
    AST_VEC_OUT: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
        arb_valid |=> CPU_VECTOR_O == $past(arb_vector))
        else $error("vector output not registered");
    AST_LEVEL_ABOVE: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
        arb_valid |-> arb_level > cpu_level)
        else $error("winner not above cpu level");
    AST_PRIO_ZERO: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
        arb_valid |-> arb_level != 4'h0)
        else $error("priority zero requested");
    AST_REQ_RAISE: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
        (arb_valid && !ACK_I) |=> CPU_REQ_O)
        else $error("request not raised");
    AST_REQ_DROP: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
        !arb_valid |=> !CPU_REQ_O)
        else $error("request without a winner");

    // cpu level: the high bit must never follow software upward
    AST_LOW_WRITE: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
        (wr_en && hit_st && !nesting_disable) |=> cpu_priority_low == $past(wdata[7:5]))
        else $error("level write lost");
    AST_LOW_HOLD: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
        !(wr_en && hit_st) |=> $stable(cpu_priority_low))
        else $error("level changed without a write");
    AST_HIGH_SET: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
        (TRAP_EVENT_I != 4'h0) |=> cpu_priority_high)
        else $error("trap did not raise the level");
    AST_HIGH_CLEAR: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
        (wr_en && hit_cc && !wdata[`ICSR_CORCTL_HIGH] && TRAP_EVENT_I == 4'h0)
        |=> !cpu_priority_high)
        else $error("high level bit not cleared");

    // control registers
    AST_NEST_WRITE: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
        (wr_en && hit_c1) |=> nesting_disable == $past(wdata[15]))
        else $error("nesting write lost");
    AST_NEST_HOLD: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
        !(wr_en && hit_c1) |=> $stable(nesting_disable))
        else $error("nesting changed without a write");
    AST_TRAP_SET: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
        (TRAP_EVENT_I != 4'h0) |=> (trap_flags & $past(TRAP_EVENT_I)) == $past(TRAP_EVENT_I))
        else $error("trap flag not set");
    AST_TRAP_HOLD: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
        !(wr_en && hit_c1) |=> (trap_flags & $past(trap_flags)) == $past(trap_flags))
        else $error("trap flag dropped without a write");
    AST_ALT_WRITE: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
        (wr_en && hit_c2) |=> alternate_table_select == $past(wdata[15]))
        else $error("table select write lost");
    AST_ALT_OUT: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
        1'b1 |=> ALT_TABLE_O == $past(alternate_table_select))
        else $error("table select output stale");
    AST_DIS_CLEAR: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
        (!DISABLE_INSTR_I) [*4] |-> !intr_disable_instr_active)
        else $error("disable status stuck");
    AST_EDGE_WRITE: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
        (wr_en && hit_c2) |=> ext_edge_polarity == $past(wdata[2:0]))
        else $error("polarity write lost");

    // bus side and event summary
    AST_UNMAPPED_ERR: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
        (PSEL_I && !PENABLE_I && !hit_any) |=> PSLVERR_O)
        else $error("unmapped access not flagged");
    AST_UNMAPPED_ZERO: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
        (rd_en && !hit_any) |=> PRDATA_O == 32'h0000_0000)
        else $error("unmapped read not zero");
    AST_MASK_WRITE: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
        (wr_en && hit_im) |=> irq_mask == $past(wdata[1:0]))
        else $error("mask write lost");
    AST_IRQ_TRAP: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
        (TRAP_EVENT_I != 4'h0) |=> irq_status[0])
        else $error("trap event not recorded");
    AST_IRQ_CLEAR: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
        (wr_en && hit_is && irq_evt == 2'h0)
        |=> irq_status == $past(irq_status & ~wdata[1:0]))
        else $error("event status clear wrong");

    COV_REQ: cover property (@(posedge CLK_SYS_I) disable iff (!RST_B_I) CPU_REQ_O);
    COV_TRAP: cover property (@(posedge CLK_SYS_I) disable iff (!RST_B_I) |TRAP_EVENT_I);
    COV_IRQ: cover property (@(posedge CLK_SYS_I) disable iff (!RST_B_I) IRQ_O);
    COV_TIE: cover property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
        arb_valid && fwd_req[0] && fwd_req[1]);
    COV_NEST_LOCK: cover property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
        nesting_disable && wr_en && hit_st);
endmodule // icsr_top
`default_nettype wire

/* File: icsr_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
module icsr_cpu_model (
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    input  wire logic ack_en_i,
    input  wire logic req_i,
    output logic      ack_o
);
    logic [1:0] wait_cnt;
    // slow core: lets the request stand a few cycles before taking it
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wait_cnt <= 2'h0;
            ack_o    <= 1'h0;
        end else if (ack_o) begin
            ack_o    <= 1'h0;
            wait_cnt <= 2'h0;
        end else if (ack_en_i && req_i) begin
            wait_cnt <= wait_cnt + 2'h1;
            ack_o    <= (wait_cnt == 2'h2);
        end else begin
            wait_cnt <= 2'h0;
        end
    end
endmodule // icsr_cpu_model
`default_nettype wire

/* File: test_interrupt_control_status_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module test_interrupt_control_status_regs;
    import icsr_pkg::*;
    typedef struct {
        logic [11:0] a;
        logic [31:0] d;
        logic [31:0] e;
        logic        err;
    } icsr_row_t;
    logic        clk = 1'h0, rst_b = 1'h0, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
    logic [11:0] paddr  = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [7:0]  src    = 8'h00;
    logic [2:0]  pin    = 3'h0;
    logic [3:0]  trap   = 4'h0, lvl;
    logic [6:0]  vec;
    logic        dis = 1'h0, ack_en = 1'h0, ack, pready, pslverr, req, alt, irq, er;
    int          error_cnt = 0, samples_checked = 0, cyc = 0;
    icsr_row_t   rows[10] = '{
        '{12'h008, 32'hFFFF_FFFF, 32'h0000_8000, 1'h0},
        '{12'h008, 32'h0000_0000, 32'h0000_0000, 1'h0},
        '{12'h000, 32'hFFFF_FFFF, 32'h0000_00E0, 1'h0},
        '{12'h000, 32'h0000_0000, 32'h0000_0000, 1'h0},
        '{12'h004, 32'hFFFF_FFFF, 32'h0000_0000, 1'h0},
        '{12'h00C, 32'hFFFF_FFFF, 32'h0000_8007, 1'h0},
        '{12'h00C, 32'h0000_0000, 32'h0000_0000, 1'h0},
        '{12'h014, 32'hFFFF_FFFF, 32'h0000_00FF, 1'h0},
        '{12'h018, 32'hFFFF_FFFF, 32'h00FF_FFFF, 1'h0},
        '{12'h040, 32'hFFFF_FFFF, 32'h0000_0000, 1'h1}};
    always #20 clk = ~clk;
    icsr_top #(.NSRC(8)) u_icsr_top (.CLK_SYS_I(clk), .RST_B_I(rst_b), .PSEL_I(psel),
        .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .SRC_EVENT_I(src),
        .EXT_PIN_I(pin), .TRAP_EVENT_I(trap), .DISABLE_INSTR_I(dis), .ACK_I(ack),
        .CPU_REQ_O(req), .CPU_VECTOR_O(vec), .CPU_LEVEL_O(lvl), .ALT_TABLE_O(alt),
        .IRQ_O(irq));
    icsr_cpu_model u_icsr_cpu_model (.clk_i(clk), .rst_b_i(rst_b), .ack_en_i(ack_en),
        .req_i(req), .ack_o(ack));
    task report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one transfer; the request is held until pready is seen high
    // no local limit: a hung wait is ended by the cycle counter below
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel   <= 1'h1;
        pen    <= 1'h0;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'h1;
        do begin
            @(posedge clk);
        end while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        pen  <= 1'h0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask
    task rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0000_0000);
        chk(rd, e);
    endtask
    // outputs are registered behind synchronisers; five edges cover the longest path
    task settle;
        repeat (5) @(posedge clk);
        @(negedge clk);
    endtask
    task pulse(input logic [7:0] s, input logic [3:0] t);
        @(posedge clk);
        src  <= s;
        trap <= t;
        @(posedge clk);
        src  <= 8'h00;
        trap <= 4'h0;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc > 10000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'h1;
        @(negedge clk);
        chk({29'h0, req, alt, irq}, 32'h0000_0000);
        for (int a = 0; a <= 36; a += 4) rdc(a[11:0], 32'h0000_0000);
        $display("reset test done");
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rdc(rows[i].a, rows[i].e);
            chk({31'h0, er}, {31'h0, rows[i].err});
        end
        $display("register table test done");
        wr(12'h014, 32'h0000_000C);
        wr(12'h018, 32'h006D_B6DB);
        pulse(8'h0F, 4'h0);
        settle();
        rdc(12'h010, 32'h0000_000F);
        chk({20'h0, req, vec, lvl}, 32'h0000_0823);
        rdc(12'h01C, 32'h0000_0203);
        wr(12'h000, 32'h0000_0060);
        settle();
        chk({31'h0, req}, 32'h0000_0000);
        wr(12'h000, 32'h0000_0040);
        settle();
        chk({31'h0, req}, 32'h0000_0001);
        wr(12'h010, 32'h0000_000B);
        settle();
        chk({25'h0, vec}, 32'h0000_0003);
        wr(12'h008, 32'h0000_8000);
        wr(12'h000, 32'h0000_00E0);
        rdc(12'h000, 32'h0000_0040);
        wr(12'h008, 32'h0000_0000);
        ack_en <= 1'h1;
        for (int n = 0; n < 20 && ack !== 1'h1; n++) @(posedge clk);
        @(negedge clk);
        chk({31'h0, req}, 32'h0000_0000);
        @(posedge clk);
        ack_en <= 1'h0;
        wr(12'h00C, 32'h0000_8000);
        settle();
        chk({31'h0, alt}, 32'h0000_0001);
        wr(12'h00C, 32'h0000_0000);
        $display("priority test done");
        for (int i = 0; i < 4; i++) begin
            pulse(8'h00, 4'h1 << i);
            settle();
            rdc(12'h008, 32'h1 << (i + 1));
            rdc(12'h004, 32'h0000_0008);
            wr(12'h008, 32'h0000_0000);
        end
        settle();
        chk({31'h0, req}, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0000_0000);
        wr(12'h024, 32'h0000_0001);
        settle();
        chk({31'h0, irq}, 32'h0000_0001);
        wr(12'h020, 32'h0000_0003);
        settle();
        chk({31'h0, irq}, 32'h0000_0000);
        wr(12'h004, 32'h0000_0000);
        rdc(12'h004, 32'h0000_0000);
        settle();
        chk({31'h0, req}, 32'h0000_0001);
        wr(12'h010, 32'h0000_0000);
        $display("trap test done");
        for (int i = 0; i < 3; i++) begin
            pin[i] <= 1'h1;
            settle();
            rdc(12'h010, 32'h1 << i);
            wr(12'h010, 32'h0000_0000);
            wr(12'h00C, 32'h1 << i);
            pin[i] <= 1'h0;
            settle();
            rdc(12'h010, 32'h1 << i);
            wr(12'h010, 32'h0000_0000);
            pin[i] <= 1'h1;
            settle();
            rdc(12'h010, 32'h0000_0000);
            wr(12'h00C, 32'h0000_0000);
            pin[i] <= 1'h0;
            settle();
            rdc(12'h010, 32'h0000_0000);
        end
        $display("edge test done");
        wr(12'h014, 32'h0000_0003);
        pulse(8'h03, 4'h0);
        settle();
        chk({20'h0, req, vec, lvl}, 32'h0000_0803);
        $display("tie test done");
        dis <= 1'h1;
        settle();
        rdc(12'h00C, 32'h0000_4000);
        dis <= 1'h0;
        settle();
        rdc(12'h00C, 32'h0000_0000);
        $display("disable test done");
        report_and_stop();
    end
endmodule // test_interrupt_control_status_regs
`default_nettype wire
